// ### verilog/psd_pkg.sv
// Overview of operation
// - peripherals are steered by cpu writes to config and task registers, and by task signals
// - events set event registers; interrupt raised only for events enabled
// - each slot owns a fixed 0x1000 byte window of 1024 words
// - slot number comes from base address: 0x40000000 is 0, 0x4001F000 is 31
// - peripherals sharing a slot number reach that slot's common registers
// - at most one peripheral of a shared slot is enabled at once
// - task fires on cpu write of one or on the task signal
// - event register stays set until cpu writes zero; new events allowed
// - one interrupt line per slot, numbered as the slot
// - set and clear registers change only bits written one; read main value
package psd_pkg;

	// =========================================================
	// address decode
	localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
	localparam logic [31:0] SLOT_SPAN = 32'h0000_1000;
	localparam int WORDS_PER_SLOT = 1024;
	localparam int REGION_HI = 31;
	localparam int REGION_LO = 17;
	localparam logic [14:0] REGION_TAG = 15'h2000;
	localparam int SLOT_HI = 16;
	localparam int SLOT_LO = 12;
	localparam int SLOT_W = 5;
	localparam int IDX_HI = 11;
	localparam int IDX_LO = 2;
	localparam int IDX_W = 10;

	// =========================================================
	// word indices inside a slot window
	localparam logic [9:0] TASK_IDX = 10'h000;
	localparam logic [9:0] EVENT_IDX = 10'h040;
	localparam logic [9:0] INTEN_IDX = 10'h0c0;
	localparam logic [9:0] INTENSET_IDX = 10'h0c1;
	localparam logic [9:0] INTENCLR_IDX = 10'h0c2;
	localparam logic [9:0] ENABLE_IDX = 10'h140;

	// =========================================================
	// field layout and reset values
	localparam int ENABLE_W = 8;
	localparam logic [7:0] ENABLE_NONE = 8'h00;
	localparam int TRIG_BIT = 0;
	localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

endpackage

// ### verilog/psd_slot_frame.sv
`timescale 1ns/10ps
module psd_slot_frame
	import psd_pkg::*;
#(
	parameter int NUM_TASKS = 4,
	parameter int NUM_EVENTS = 4,
	parameter int NUM_SUBS = 2
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register access from the decoder
	input wire logic acc_wr,
	input wire logic [IDX_W-1:0] acc_idx,
	input wire logic [31:0] acc_wdata,
	output logic [31:0] acc_rdata,
	// peripheral side
	input wire logic [NUM_TASKS-1:0] task_sig,
	input wire logic [NUM_EVENTS-1:0] event_sig,
	output logic [NUM_TASKS-1:0] task_fire,
	output logic [NUM_SUBS-1:0] sub_enable,
	output logic irq
);

	logic [NUM_TASKS-1:0] task_fire_ff;
	logic [NUM_EVENTS-1:0] event_ff;
	logic [NUM_EVENTS-1:0] inten_ff;
	logic [ENABLE_W-1:0] enable_ff;
	logic [ENABLE_W-1:0] nxt_enable;
	logic [NUM_SUBS-1:0] sub_enable_ff;
	logic irq_ff;
	logic active;
	logic [NUM_EVENTS-1:0] evt_clr;
	logic [NUM_EVENTS-1:0] wdata_ev;

	// word hit inside a register group
	function automatic logic hit(input logic [IDX_W-1:0] idx,
		input logic [IDX_W-1:0] base, input int ofs);
		hit = (idx == base + IDX_W'(ofs));
	endfunction

	// tasks and events only act while a peripheral is enabled
	assign active = (enable_ff != ENABLE_NONE);
	assign wdata_ev = acc_wdata[NUM_EVENTS-1:0];

	// =========================================================
	// tasks: one-cycle pulse per trigger
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			task_fire_ff <= '0;
		end else begin
			for (int i = 0; i < NUM_TASKS; i++) begin
				task_fire_ff[i] <= active && ((acc_wr && hit(acc_idx, TASK_IDX, i)
					&& acc_wdata[TRIG_BIT]) || task_sig[i]);
			end
		end
	end

	// =========================================================
	// events: sticky, set wins over a same-cycle clear
	always_comb begin
		for (int i = 0; i < NUM_EVENTS; i++) begin
			evt_clr[i] = acc_wr && hit(acc_idx, EVENT_IDX, i)
				&& !acc_wdata[TRIG_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			event_ff <= '0;
		end else begin
			for (int i = 0; i < NUM_EVENTS; i++) begin
				if (active && event_sig[i]) begin
					event_ff[i] <= 1'b1;
				end else if (evt_clr[i]) begin
					event_ff[i] <= 1'b0;
				end
			end
		end
	end

	// =========================================================
	// interrupt enable with set and clear aliases
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			inten_ff <= '0;
		end else if (acc_wr && acc_idx == INTEN_IDX) begin
			inten_ff <= wdata_ev;
		end else if (acc_wr && acc_idx == INTENSET_IDX) begin
			inten_ff <= inten_ff | wdata_ev;
		end else if (acc_wr && acc_idx == INTENCLR_IDX) begin
			inten_ff <= inten_ff & ~wdata_ev;
		end
	end

	// one line per slot; one cycle behind the event flags
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(event_ff & inten_ff);
		end
	end

	// =========================================================
	// enable: a code picks one sharing peripheral; a switch while
	// one is running is refused rather than trusted to software
	always_comb begin
		nxt_enable = enable_ff;
		if (acc_wr && acc_idx == ENABLE_IDX) begin
			if (acc_wdata[ENABLE_W-1:0] == ENABLE_NONE) begin
				nxt_enable = ENABLE_NONE;
			end else if (!active
				&& acc_wdata[ENABLE_W-1:0] <= ENABLE_W'(NUM_SUBS)) begin
				nxt_enable = acc_wdata[ENABLE_W-1:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			enable_ff <= ENABLE_NONE;
			sub_enable_ff <= '0;
		end else begin
			enable_ff <= nxt_enable;
			for (int k = 0; k < NUM_SUBS; k++) begin
				sub_enable_ff[k] <= (nxt_enable == ENABLE_W'(k + 1));
			end
		end
	end

	// =========================================================
	// read mux; set and clear aliases show the main value
	always_comb begin
		acc_rdata = RDATA_NONE;
		if (acc_idx == INTEN_IDX || acc_idx == INTENSET_IDX
			|| acc_idx == INTENCLR_IDX) begin
			acc_rdata[NUM_EVENTS-1:0] = inten_ff;
		end else if (acc_idx == ENABLE_IDX) begin
			acc_rdata[ENABLE_W-1:0] = enable_ff;
		end else begin
			for (int i = 0; i < NUM_EVENTS; i++) begin
				if (hit(acc_idx, EVENT_IDX, i)) begin
					acc_rdata[TRIG_BIT] = event_ff[i];
				end
			end
		end
	end

	assign task_fire = task_fire_ff;
	assign sub_enable = sub_enable_ff;
	assign irq = irq_ff;

	// =========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_event_hold: assert property (
		1 |=> (($past(event_ff) & ~$past(evt_clr) & ~event_ff) == '0))
		else $error("event flag dropped without a clear");
	chk_event_catch: assert property (
		active |=> (($past(event_sig) & ~event_ff) == '0))
		else $error("event not captured");
	chk_irq_gate: assert property (
		(inten_ff == '0) [*2] |-> !irq_ff)
		else $error("interrupt without enabled event");
	chk_set_alias: assert property (
		acc_wr && acc_idx == INTENSET_IDX
		|=> (($past(wdata_ev) & ~inten_ff) == '0))
		else $error("set alias lost a bit");
	chk_task_write: assert property (
		active && acc_wr && acc_idx == TASK_IDX && acc_wdata[TRIG_BIT]
		|=> task_fire_ff[0] ##1 (!task_fire_ff[0] || $past(task_sig[0])
		|| $past(acc_wr && acc_idx == TASK_IDX && acc_wdata[TRIG_BIT])))
		else $error("task write did not fire");
	chk_one_enabled: assert property (
		$onehot0(sub_enable_ff))
		else $error("two sharing peripherals enabled");
	chk_switch_refused: assert property (
		active && acc_wr && acc_idx == ENABLE_IDX
		&& acc_wdata[ENABLE_W-1:0] != ENABLE_NONE
		|=> $stable(enable_ff))
		else $error("enable switched without disable");

	cov_irq_raised: cover property (irq_ff);
	cov_clear_race: cover property (active && event_sig[0] && evt_clr[0]);
endmodule // psd_slot_frame

// ### verilog/psd_slot_decoder.sv
`timescale 1ns/10ps
module psd_slot_decoder
	import psd_pkg::*;
#(
	parameter int NUM_SLOTS = 32,
	parameter int NUM_TASKS = 4,
	parameter int NUM_EVENTS = 4,
	parameter int NUM_SUBS = 2
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// cpu request
	input wire logic cpu_valid,
	input wire logic cpu_write,
	input wire logic [31:0] cpu_addr,
	input wire logic [31:0] cpu_wdata,
	// cpu answer
	output logic resp_valid,
	output logic [31:0] resp_rdata,
	// peripheral slots
	input wire logic [NUM_SLOTS*NUM_TASKS-1:0] task_sig,
	input wire logic [NUM_SLOTS*NUM_EVENTS-1:0] event_sig,
	output logic [NUM_SLOTS*NUM_TASKS-1:0] task_fire,
	output logic [NUM_SLOTS*NUM_SUBS-1:0] sub_enable,
	output logic [NUM_SLOTS-1:0] irq
);

	logic in_region;
	logic [SLOT_W-1:0] slot_sel;
	logic [IDX_W-1:0] word_idx;
	logic [31:0] frame_rdata [NUM_SLOTS];
	logic [NUM_SLOTS-1:0] slot_wr;
	logic resp_valid_ff;
	logic [31:0] resp_rdata_ff;
	logic [31:0] nxt_rdata;

	// =========================================================
	// decode: region tag, slot number, word in the slot window
	assign in_region = (cpu_addr[REGION_HI:REGION_LO] == REGION_TAG);
	assign slot_sel = cpu_addr[SLOT_HI:SLOT_LO];
	assign word_idx = cpu_addr[IDX_HI:IDX_LO];

	// =========================================================
	// one register frame per slot; sharing peripherals meet here
	for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
		assign slot_wr[s] = cpu_valid && cpu_write && in_region
			&& slot_sel == SLOT_W'(s);

		psd_slot_frame #(
			.NUM_TASKS(NUM_TASKS),
			.NUM_EVENTS(NUM_EVENTS),
			.NUM_SUBS(NUM_SUBS)
		) u_frame (
			.clock(clock),
			.rst_n(rst_n),
			.acc_wr(slot_wr[s]),
			.acc_idx(word_idx),
			.acc_wdata(cpu_wdata),
			.acc_rdata(frame_rdata[s]),
			.task_sig(task_sig[s*NUM_TASKS +: NUM_TASKS]),
			.event_sig(event_sig[s*NUM_EVENTS +: NUM_EVENTS]),
			.task_fire(task_fire[s*NUM_TASKS +: NUM_TASKS]),
			.sub_enable(sub_enable[s*NUM_SUBS +: NUM_SUBS]),
			.irq(irq[s])
		);
	end

	// =========================================================
	// read data: outside the region, or past the slot count, reads zero
	always_comb begin
		nxt_rdata = RDATA_NONE;
		if (cpu_valid && !cpu_write && in_region
			&& 32'(slot_sel) < 32'(NUM_SLOTS)) begin
			nxt_rdata = frame_rdata[slot_sel];
		end
	end

	// answer one cycle after every request, mapped or not
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			resp_valid_ff <= 1'b0;
			resp_rdata_ff <= RDATA_NONE;
		end else begin
			resp_valid_ff <= cpu_valid;
			resp_rdata_ff <= nxt_rdata;
		end
	end

	assign resp_valid = resp_valid_ff;
	assign resp_rdata = resp_rdata_ff;

	// =========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_resp_timing: assert property (
		$past(rst_n) |-> resp_valid_ff == $past(cpu_valid))
		else $error("answer not one cycle after request");
	chk_unmapped_zero: assert property (
		cpu_valid && !in_region |=> resp_rdata_ff == RDATA_NONE)
		else $error("unmapped access returned data");
	chk_one_slot_wr: assert property (
		$onehot0(slot_wr))
		else $error("write reached two slots");

	cov_last_slot: cover property (slot_wr[NUM_SLOTS-1]);
	cov_read_mapped: cover property (cpu_valid && !cpu_write && in_region);
	cov_unmapped: cover property (cpu_valid && !in_region);
endmodule // psd_slot_decoder

// ### sim/psd_cpu_model.sv
`timescale 1ns/10ps
module psd_cpu_model (
	// clock
	input wire logic clock,
	// request towards the decoder
	output logic cpu_valid,
	output logic cpu_write,
	output logic [31:0] cpu_addr,
	output logic [31:0] cpu_wdata,
	// answer from the decoder
	input wire logic resp_valid,
	input wire logic [31:0] resp_rdata
);
	// quiet bus at time zero
	initial begin
		cpu_valid = 1'b0;
		cpu_write = 1'b0;
		cpu_addr = 32'h0;
		cpu_wdata = 32'h0;
	end

	// one strobed request; answer taken one cycle later
	task automatic xfer(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic ack, output logic [31:0] q);
		@(posedge clock);
		#1;
		cpu_valid = 1'b1;
		cpu_write = wr;
		cpu_addr = a;
		cpu_wdata = d;
		@(posedge clock);
		#1;
		ack = resp_valid;
		q = resp_rdata;
		cpu_valid = 1'b0;
		// released lines flip, so a stale copy is never mistaken for data
		cpu_addr = ~cpu_addr;
		cpu_wdata = ~cpu_wdata;
	endtask
endmodule // psd_cpu_model

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	// =========================================================
	// signals and reference state
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic cpu_valid, cpu_write, resp_valid, ack;
	logic [31:0] cpu_addr, cpu_wdata, resp_rdata, rdata, base, irq;
	logic [127:0] task_sig = '0, event_sig = '0, task_fire;
	logic [63:0] sub_enable;
	int mismatches = 0, tests_run = 0, seed = 78, s, k, i;
	int en_m[32];
	logic [3:0] ev_m[32], ie_m[32];

	// 40 MHz
	always #12.5 clock = ~clock;

	psd_slot_decoder psd_slot_decoder_inst (.clock(clock), .rst_n(rst_n),
		.cpu_valid(cpu_valid), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
		.cpu_wdata(cpu_wdata), .resp_valid(resp_valid),
		.resp_rdata(resp_rdata), .task_sig(task_sig), .event_sig(event_sig),
		.task_fire(task_fire), .sub_enable(sub_enable), .irq(irq));
	psd_cpu_model psd_cpu_model_inst (.clock(clock), .cpu_valid(cpu_valid),
		.cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.resp_valid(resp_valid), .resp_rdata(resp_rdata));

	// =========================================================
	// reference model
	function automatic logic [31:0] m_read(logic [31:0] a);
		int t;
		t = a[16:12];
		if (a[31:17] != 15'h2000) return 32'h0;
		if (a[11:4] == 8'h10) return {31'h0, ev_m[t][a[3:2]]};
		if (a[11:2] >= 10'h0c0 && a[11:2] <= 10'h0c2) return {28'h0, ie_m[t]};
		if (a[11:2] == 10'h140) return 32'(en_m[t]);
		return 32'h0;
	endfunction
	task automatic m_write(logic [31:0] a, logic [31:0] d);
		int t;
		t = a[16:12];
		if (a[31:17] != 15'h2000) return;
		case (a[11:2])
		10'h0c0: ie_m[t] = d[3:0];
		10'h0c1: ie_m[t] |= d[3:0];
		10'h0c2: ie_m[t] &= ~d[3:0];
		// a direct switch between sharing peripherals is refused
		10'h140: if (d == 0)
			en_m[t] = 0;
		else if (en_m[t] == 0 && d <= 2)
			en_m[t] = d;
		default: if (a[11:4] == 8'h10 && !d[0])
			ev_m[t][a[3:2]] = 1'b0;
		endcase
	endtask
	function automatic logic [31:0] exp_irq();
		logic [31:0] r;
		for (int t = 0; t < 32; t++)
			r[t] = |(ev_m[t] & ie_m[t]);
		return r;
	endfunction
	function automatic logic [63:0] exp_sub();
		logic [63:0] r;
		r = '0;
		for (int t = 0; t < 32; t++)
			if (en_m[t] != 0)
				r[t * 2 + en_m[t] - 1] = 1'b1;
		return r;
	endfunction

	// =========================================================
	// compares, bus access and closing
	task automatic cmp_rdata(logic [31:0] got, logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bits(logic [127:0] got, logic [127:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(logic [31:0] a, logic [31:0] d);
		psd_cpu_model_inst.xfer(1'b1, a, d, ack, rdata);
		m_write(a, d);
		cmp_bits(ack, 1'b1);
	endtask
	task automatic rd(logic [31:0] a);
		psd_cpu_model_inst.xfer(1'b0, a, 32'h0, ack, rdata);
		cmp_bits(ack, 1'b1);
		cmp_rdata(rdata, m_read(a));
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#(25 * 20000);
		mismatches++;
		wrap_up();
	end

	// =========================================================
	// main sequence
	initial begin
		for (i = 0; i < 32; i++) begin
			en_m[i] = 0;
			ev_m[i] = 4'h0;
			ie_m[i] = 4'h0;
		end
		repeat (8) @(posedge clock);
		#1 rst_n = 1'b1;
		cmp_bits(irq, 128'h0);
		cmp_bits(sub_enable, 128'h0);
		// each window: reset value, enable, refused direct switch
		for (s = 0; s < 32; s++) begin
			base = 32'h4000_0000 + s * 32'h1000;
			k = 1 + ($random(seed) & 1);
			rd(base + 32'h500);
			wr(base + 32'h500, k);
			wr(base + 32'h500, 3 - k);
			rd(base + 32'h500);
		end
		cmp_bits(sub_enable, exp_sub());
		// legal switch: disable first, then enable the other one
		k = en_m[5];
		wr(32'h4000_5500, 0);
		wr(32'h4000_5500, 3 - k);
		rd(32'h4000_5500);
		cmp_bits(sub_enable, exp_sub());
		// slot 6 off: a code past the last peripheral is refused,
		// and tasks and events are ignored until it is enabled again
		wr(32'h4000_6500, 0);
		wr(32'h4000_6500, 3);
		rd(32'h4000_6500);
		wr(32'h4000_6000, 1);
		cmp_bits(task_fire, 128'h0);
		@(posedge clock);
		#1 event_sig = 128'h1 << 24;
		@(posedge clock);
		#1 event_sig = 128'h0;
		if (en_m[6] != 0)
			ev_m[6][0] = 1'b1;
		rd(32'h4000_6100);
		wr(32'h4000_6500, 1);
		cmp_bits(sub_enable, exp_sub());
		// outside region aliases slot 0 in low bits; must not touch it
		wr(32'h4002_0500, 0);
		rd(32'h4002_0500);
		rd(32'h4000_0500);
		rd(32'h4000_0ffc);
		// tasks by register and by signal on a random slot
		s = $unsigned($random(seed)) % 32;
		base = 32'h4000_0000 + s * 32'h1000;
		for (i = 0; i < 4; i++) begin
			wr(base + i * 4, 1);
			cmp_bits(task_fire, 128'h1 << (s * 4 + i));
			@(posedge clock);
			#1 task_sig = 128'h1 << (s * 4 + i);
			@(posedge clock);
			#1 task_sig = 128'h0;
			cmp_bits(task_fire, 128'h1 << (s * 4 + i));
		end
		// interrupt mask through set and clear
		wr(base + 32'h304, 32'h5);
		wr(base + 32'h308, 32'h1);
		rd(base + 32'h300);
		rd(base + 32'h308);
		// events, also while already set; odd passes write one
		for (i = 0; i < 10; i++) begin
			k = $unsigned($random(seed)) % 4;
			@(posedge clock);
			#1 event_sig = 128'h1 << (s * 4 + k);
			@(posedge clock);
			#1 event_sig = 128'h0;
			// events only land while the slot is enabled
			if (en_m[s] != 0)
				ev_m[s][k] = 1'b1;
			rd(base + 32'h100 + k * 4);
			cmp_bits(irq, exp_irq());
			wr(base + 32'h100 + k * 4, i & 1);
			@(posedge clock);
			#1;
			cmp_bits(irq, exp_irq());
		end
		wr(base + 32'h308, 32'hf);
		@(posedge clock);
		#1;
		cmp_bits(irq, exp_irq());
		wrap_up();
	end
endmodule // tb_top
